// [shared/ast_pkg.sv]
// Shared constants and types of the asynchronous serial transceiver.
package ast_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int unsigned AST_AW   = 8;
   localparam int unsigned AST_DW   = 32;
   localparam logic [7:0] AST_ADDR_STATUS = 8'h00;
   localparam logic [7:0] AST_ADDR_CTRL1  = 8'h04;
   localparam logic [7:0] AST_ADDR_CTRL2  = 8'h08;
   localparam logic [7:0] AST_ADDR_BAUD   = 8'h0C;
   localparam logic [7:0] AST_ADDR_DATA   = 8'h10;

   // serial_control_first fields.
   localparam int unsigned AST_C1_TX9  = 0;
   localparam int unsigned AST_C1_RX9  = 1;
   localparam int unsigned AST_C1_BRK  = 2;
   localparam int unsigned AST_C1_STOP = 3;
   localparam int unsigned AST_C1_PRT  = 4;
   localparam int unsigned AST_C1_PEN  = 5;
   localparam int unsigned AST_C1_LEN  = 6;
   localparam int unsigned AST_C1_EN   = 7;

   // serial_control_second fields.
   localparam int unsigned AST_C2_TEIE = 0;
   localparam int unsigned AST_C2_TIIE = 1;
   localparam int unsigned AST_C2_RIE  = 2;
   localparam int unsigned AST_C2_OIE  = 3;
   localparam int unsigned AST_C2_ADIE = 4;
   localparam int unsigned AST_C2_ADEN = 5;
   localparam int unsigned AST_C2_RECEIVE_ENABLE = 6;
   localparam int unsigned AST_C2_TRANSMIT_ENABLE = 7;

   // serial_status_reg fields.
   localparam int unsigned AST_S_PARITY_FAULT_FLAG  = 0;
   localparam int unsigned AST_S_NF    = 1;
   localparam int unsigned AST_S_FRAMING_FLAG  = 2;
   localparam int unsigned AST_S_OVERRUN_FLAG  = 3;
   localparam int unsigned AST_S_RECEIVE_IDLE_FLAG = 4;
   localparam int unsigned AST_S_RXF   = 5;
   localparam int unsigned AST_S_TRANSMIT_IDLE_FLAG = 6;
   localparam int unsigned AST_S_TXE   = 7;
   localparam int unsigned AST_S_ADDR  = 8;

   // Reset values.
   localparam logic [7:0] AST_CTRL1_RST = 8'h00;
   localparam logic [7:0] AST_CTRL2_RST = 8'h00;
   localparam logic [7:0] AST_BAUD_RST  = 8'h00;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam logic [3:0] AST_OS_LAST    = 4'hF;
   localparam logic [3:0] AST_VOTE_FIRST = 4'h7;
   localparam logic [3:0] AST_VOTE_LAST  = 4'h9;
   localparam logic [3:0] AST_BREAK_BITS = 4'hD;
   localparam logic [3:0] AST_DBITS_8    = 4'h8;
   localparam int unsigned AST_FIFO_DEPTH = 2;

   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {AST_TX_IDLE, AST_TX_SHIFT, AST_TX_BREAK} ast_tx_e;
   typedef enum logic {AST_RX_IDLE, AST_RX_RUN} ast_rx_e;

endpackage : ast_pkg

// [verif/ast_monitor.sv]
// Port checker for the serial transceiver.
`timescale 1ns/1ps
`default_nettype none
module ast_monitor (
   input wire logic                       sys_clk,
   input wire logic                       reset,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [ast_pkg::AST_AW-1:0] paddr,
   input wire logic [ast_pkg::AST_DW-1:0] pwdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire logic                       tx_pin,
   input wire logic                       tx_pin_oe,
   input wire logic                       rx_serial_sel,
   input wire logic                       rx_pullup_off
);
   import ast_pkg::*;
   logic mapped;
   assign mapped = paddr inside {AST_ADDR_STATUS, AST_ADDR_CTRL1,
      AST_ADDR_CTRL2, AST_ADDR_BAUD, AST_ADDR_DATA};
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   a_ready_latency: assert property (psel && !penable |=> pready)
      else $error("pready late");
   a_unmapped_error: assert property (pready && !mapped |-> pslverr)
      else $error("unmapped address accepted");
   a_mapped_clean: assert property (pready && mapped |-> !pslverr)
      else $error("mapped address refused");
   a_pullup_follows: assert property (rx_pullup_off == rx_serial_sel)
      else $error("pull-high not tied to receive pin");
   a_start_hold: assert property ($fell(tx_pin) |-> !tx_pin [*8])
      else $error("start bit too short");
   a_idle_high: assert property (
      !tx_pin_oe && !$past(tx_pin_oe) |-> tx_pin)
      else $error("released line not high");
   a_disable_pins: assert property (pready && pwrite &&
      paddr == AST_ADDR_CTRL1 && !pwdata[AST_C1_EN]
      |-> ##[1:2] !tx_pin_oe && !rx_serial_sel)
      else $error("pins kept after global disable");
endmodule : ast_monitor
bind ast_top ast_monitor mon_u (.sys_clk, .reset, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pready, .pslverr, .tx_pin, .tx_pin_oe, .rx_serial_sel,
   .rx_pullup_off);
`default_nettype wire

// [verif/ast_peer.sv]
// Behavioural far-end serial device.
`timescale 1ns/1ps
`default_nettype none
module ast_peer (
   input  wire logic sys_clk,
   input  wire logic tx_pin,
   output logic      rx_pin
);
   // Matches a divisor of zero: sixteen ticks of one clock per bit.
   int bit_clks = 16;
   initial rx_pin = 1'b1;
   task automatic send(input logic [11:0] b, input int n);
      @(posedge sys_clk);
      rx_pin <= 1'b0;
      repeat (bit_clks) @(posedge sys_clk);
      for (int i = 0; i < n; i++) begin
         rx_pin <= b[i];
         repeat (bit_clks) @(posedge sys_clk);
      end
      rx_pin <= 1'b1;
   endtask : send
   task automatic recv(input int n, output logic [11:0] b);
      int t;
      b = '1;
      t = 0;
      while (tx_pin !== 1'b0 && t < 5000) begin
         @(posedge sys_clk);
         t++;
      end
      // An all-zero result tells the bench that no frame ever started.
      if (t == 5000) begin
         b = '0;
         return;
      end
      // Sampling mid-bit keeps a one-clock skew from flipping a bit.
      repeat (bit_clks / 2) @(posedge sys_clk);
      for (int i = 0; i < n; i++) begin
         repeat (bit_clks) @(posedge sys_clk);
         b[i] = tx_pin;
      end
   endtask : recv
endmodule : ast_peer
`default_nettype wire

// [verif/ast_top_bench.sv]
// Self-checking bench for the serial transceiver.
`timescale 1ns/1ps
`default_nettype none
module ast_top_bench;
   import ast_pkg::*;
   logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr, irq;
   logic        rx_pin, tx_pin, tx_pin_oe, rx_serial_sel, rx_pullup_off, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic [11:0] f, x;
   logic [7:0]  modes [5] = '{8'h80, 8'hA0, 8'hB0, 8'h88, 8'hC0};
   int          bad_count = 0, checked = 0, n;
   ast_top dut_u (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .rx_pin, .tx_pin, .tx_pin_oe,
      .rx_serial_sel, .rx_pullup_off, .irq);
   ast_peer peer_u (.sys_clk, .tx_pin, .rx_pin);
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task end_sim;
      $display("mismatches %0d of %0d checks", bad_count, checked);
      if (bad_count == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s got %h", $time, s, got);
      end
   endtask : chk
   // One APB transfer; read data and error land in q and e.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge sys_clk);
         t++;
      end while (pready !== 1'b1 && t < 20);
      if (pready !== 1'b1) begin
         bad_count++;
         $display("unexpected at %0t: no pready", $time);
         end_sim;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic [11:0] frame(input logic [7:0] c, output int k);
      logic [11:0] v;
      v = {4'hF, 8'hB5};
      k = 8;
      if (c[AST_C1_LEN]) begin
         v[8] = c[AST_C1_TX9];
         k++;
      end
      if (c[AST_C1_PEN]) begin
         v[k] = ^v[7:0] ^ c[AST_C1_PRT];
         k++;
      end
      k = k + 1 + int'(c[AST_C1_STOP]);
      return v;
   endfunction : frame
   task rx_byte(input logic [7:0] d, input logic stop);
      peer_u.send({3'h7, stop, d}, 9);
      repeat (40) @(posedge sys_clk);
   endtask : rx_byte
   initial begin
      {reset, psel, penable, pwrite, paddr, pwdata} = {4'h8, 40'h0};
      repeat (12) @(posedge sys_clk);
      reset <= 1'b0;
      apb(0, AST_ADDR_CTRL2, 0);
      chk(q, 0, "ctrl2 reset");
      apb(0, AST_ADDR_STATUS, 0);
      chk(q[7:0], 8'hD0, "idle status");
      apb(0, 8'h14, 0);
      chk({e, q}, 33'h1_0000_0000, "unmapped");
      apb(1, AST_ADDR_BAUD, 0);
      apb(1, AST_ADDR_CTRL1, 32'h80);
      apb(1, AST_ADDR_CTRL2, 32'hC0);
      repeat (3) @(posedge sys_clk);
      chk({tx_pin_oe, rx_serial_sel, rx_pullup_off}, 3'h7, "pins");
      foreach (modes[i]) begin
         apb(1, AST_ADDR_CTRL1, {24'h0, modes[i]});
         x = frame(modes[i], n);
         apb(1, AST_ADDR_DATA, 32'hB5);
         peer_u.recv(n, f);
         chk(f, x, "tx frame");
         if (f === 12'h000) end_sim;
      end
      // Break must still be low well past its start, and end once cleared.
      apb(1, AST_ADDR_CTRL1, 32'h84);
      repeat (200) @(posedge sys_clk);
      chk(tx_pin, 0, "break low");
      apb(1, AST_ADDR_CTRL1, 32'h80);
      repeat (100) @(posedge sys_clk);
      chk(tx_pin, 1, "break end");
      rx_byte(8'h3C, 1'b1);
      apb(0, AST_ADDR_STATUS, 0);
      chk(q[AST_S_RXF], 1, "rx full");
      apb(0, AST_ADDR_DATA, 0);
      chk(q[7:0], 8'h3C, "rx data");
      rx_byte(8'h11, 1'b1);
      rx_byte(8'h22, 1'b1);
      rx_byte(8'h33, 1'b1);
      apb(0, AST_ADDR_STATUS, 0);
      chk(q[AST_S_OVERRUN_FLAG], 1, "overrun");
      apb(0, AST_ADDR_DATA, 0);
      chk(q[7:0], 8'h11, "first kept");
      apb(0, AST_ADDR_DATA, 0);
      chk(q[7:0], 8'h22, "second kept");
      rx_byte(8'h55, 1'b0);
      apb(0, AST_ADDR_STATUS, 0);
      chk(q[AST_S_FRAMING_FLAG], 1, "framing");
      apb(0, AST_ADDR_DATA, 0);
      // Even parity over 8'h01 needs a one; a zero must be flagged.
      apb(1, AST_ADDR_CTRL1, 32'hA0);
      peer_u.send({3'h7, 1'b0, 8'h01}, 10);
      repeat (40) @(posedge sys_clk);
      apb(0, AST_ADDR_STATUS, 0);
      chk(q[AST_S_PARITY_FAULT_FLAG], 1, "parity");
      apb(0, AST_ADDR_DATA, 0);
      apb(1, AST_ADDR_CTRL1, 0);
      apb(0, AST_ADDR_CTRL2, 0);
      chk(q[7:6], 0, "enables dropped");
      apb(0, AST_ADDR_STATUS, 0);
      chk(q[7:0], 8'hD0, "flags reset");
      chk({tx_pin_oe, rx_serial_sel}, 0, "pins freed");
      apb(1, AST_ADDR_CTRL1, 32'h80);
      apb(1, AST_ADDR_CTRL2, 32'h74);
      repeat (3) @(posedge sys_clk);
      chk({tx_pin_oe, rx_serial_sel}, 1, "rx only");
      chk(irq, 0, "irq quiet");
      rx_byte(8'hA5, 1'b1);
      chk(irq, 1, "irq raised");
      apb(0, AST_ADDR_STATUS, 0);
      chk(q[AST_S_ADDR], 1, "address seen");
      apb(0, AST_ADDR_DATA, 0);
      chk(q[7:0], 8'hA5, "rx alone");
      repeat (2) @(posedge sys_clk);
      chk(irq, 0, "irq cleared");
      end_sim;
   end
endmodule : ast_top_bench
`default_nettype wire

// [verilog/ast_baud.sv]
// Baud generator: 8-bit prescaler giving a 16x oversampling tick.
`timescale 1ns/1ps
`default_nettype none
module ast_baud (
   input  wire logic       sys_clk,
   input  wire logic       reset,
   input  wire logic       clear,
   input  wire logic [7:0] divisor,
   output logic            os_tick
);
   import ast_pkg::*;

   logic [7:0] cnt_ff;
   logic [7:0] nxt_cnt;
   logic       tick_ff;
   logic       nxt_tick;

   // A tick every divisor+1 clocks; the bit time is sixteen ticks.
   always_comb begin
      nxt_cnt  = cnt_ff + 8'h01;
      nxt_tick = 1'b0;
      if (clear) begin
         nxt_cnt = 8'h00;
      end else if (cnt_ff >= divisor) begin
         nxt_cnt  = 8'h00;
         nxt_tick = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cnt_ff  <= 8'h00;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign os_tick = tick_ff;

endmodule : ast_baud
`default_nettype wire

// [verilog/ast_top.sv]
// Asynchronous serial transceiver with APB register access.
`timescale 1ns/1ps
`default_nettype none
module ast_top (
   input  wire logic                        sys_clk,
   input  wire logic                        reset,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [ast_pkg::AST_AW-1:0]  paddr,
   input  wire logic [ast_pkg::AST_DW-1:0]  pwdata,
   output logic      [ast_pkg::AST_DW-1:0]  prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        rx_pin,
   output logic                             tx_pin,
   output logic                             tx_pin_oe,
   output logic                             rx_serial_sel,
   output logic                             rx_pullup_off,
   output logic                             irq
);
   import ast_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [7:0]  ctrl1_ff, nxt_ctrl1, ctrl2_ff, nxt_ctrl2, baud_ff, nxt_baud;
   logic [31:0] prdata_ff, nxt_prdata;
   logic        pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
   logic        irq_ff, nxt_irq, stat_rd_ff, nxt_stat_rd;
   logic        pe_ff, nxt_pe, fe_ff, nxt_fe, nf_ff, nxt_nf;
   logic        ov_ff, nxt_ov, adr_ff, nxt_adr;
   logic [8:0]  fifo_ff [AST_FIFO_DEPTH];
   logic [8:0]  nxt_fifo [AST_FIFO_DEPTH];
   logic        wp_ff, nxt_wp, rp_ff, nxt_rp;
   logic [1:0]  cnt_ff, nxt_cnt;
   ast_tx_e     tx_st_ff, nxt_tx_st;
   logic [8:0]  hold_ff, nxt_hold;
   logic        hold_vld_ff, nxt_hold_vld;
   logic [11:0] frame_ff, nxt_frame;
   logic [3:0]  tx_bit_ff, nxt_tx_bit, tx_os_ff, nxt_tx_os;
   logic        line_ff, nxt_line;
   ast_rx_e     rx_st_ff, nxt_rx_st;
   logic        rx_s1_ff, rx_s2_ff, rx_prev_ff;
   logic [3:0]  rx_os_ff, nxt_rx_os, rx_idx_ff, nxt_rx_idx;
   logic [11:0] rx_bits_ff, nxt_rx_bits;
   logic [2:0]  vote_ff, nxt_vote;
   logic        noise_ff, nxt_noise;
   logic        acc, wr_data, rd_data, rd_stat, os_tick;
   logic        en, te, re, nine, pen, parity_type_select, two;
   logic        rx_done, rx_pe, rx_fe, rx_nf;
   logic [8:0]  rx_word;
   logic [3:0]  dbits;
   logic [3:0]  rx_last, tx_last;
   logic [8:0]  status;

   // Majority of three samples per bit; disagreement marks noise.
   function automatic logic ast_maj(input logic [2:0] v);
      return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction : ast_maj

   // Builds the whole frame so the shifter only ever sends bit 0.
   function automatic logic [11:0] ast_frame(input logic [8:0] d,
                                             input logic nine_b,
                                             input logic pen_b,
                                             input logic prt_b);
      logic [11:0] f;
      logic        p;
      f = 12'hFFF;
      f[0] = 1'b0;
      f[8:1] = d[7:0];
      if (nine_b) f[9] = d[8];
      p = (nine_b ? ^d : ^d[7:0]) ^ prt_b;
      if (pen_b) f[nine_b ? 10 : 9] = p;
      return f;
   endfunction : ast_frame

   ast_baud u_baud (
      .sys_clk (sys_clk),
      .reset   (reset),
      .clear   (!en),
      .divisor (baud_ff),
      .os_tick (os_tick)
   );

   assign en    = ctrl1_ff[AST_C1_EN];
   assign te    = ctrl2_ff[AST_C2_TRANSMIT_ENABLE] & en;
   assign re    = ctrl2_ff[AST_C2_RECEIVE_ENABLE] & en;
   assign nine  = ctrl1_ff[AST_C1_LEN];
   assign pen   = ctrl1_ff[AST_C1_PEN];
   assign parity_type_select   = ctrl1_ff[AST_C1_PRT];
   assign two   = ctrl1_ff[AST_C1_STOP];
   assign dbits = AST_DBITS_8 + {3'b000, nine};
   assign rx_last = dbits + {3'b000, pen} + 4'h1;
   assign tx_last = rx_last + {3'b000, two};
   assign acc     = psel & penable & pready_ff;
   assign wr_data = acc & pwrite & (paddr == AST_ADDR_DATA);
   assign rd_data = acc & !pwrite & (paddr == AST_ADDR_DATA);
   assign rd_stat = acc & !pwrite & (paddr == AST_ADDR_STATUS);
   assign status = {adr_ff, !hold_vld_ff,
                    !hold_vld_ff & (tx_st_ff == AST_TX_IDLE),
                    cnt_ff != 2'b00, rx_st_ff == AST_RX_IDLE,
                    ov_ff, fe_ff, nf_ff, pe_ff};

   // ----------------------------------------------------------------
   // Registers, receive buffer and flags
   // ----------------------------------------------------------------
   always_comb begin
      nxt_ctrl1 = ctrl1_ff;
      nxt_ctrl2 = ctrl2_ff;
      nxt_baud  = baud_ff;
      nxt_prdata = prdata_ff;
      nxt_pready = 1'b0;
      nxt_pslverr = pslverr_ff;
      nxt_stat_rd = stat_rd_ff;
      nxt_pe = pe_ff;
      nxt_fe = fe_ff;
      nxt_nf = nf_ff;
      nxt_ov = ov_ff;
      nxt_adr = adr_ff;
      nxt_fifo = fifo_ff;
      nxt_wp = wp_ff;
      nxt_rp = rp_ff;
      nxt_cnt = cnt_ff;
      if (psel && !penable) begin
         nxt_pready  = 1'b1;
         nxt_pslverr = 1'b0;
         nxt_prdata  = 32'h0000_0000;
         case (paddr)
            AST_ADDR_STATUS: nxt_prdata[8:0] = status;
            AST_ADDR_CTRL1: begin
               nxt_prdata[7:0] = ctrl1_ff;
               nxt_prdata[AST_C1_RX9] = fifo_ff[rp_ff][8];
            end
            AST_ADDR_CTRL2: nxt_prdata[7:0] = ctrl2_ff;
            AST_ADDR_BAUD:  nxt_prdata[7:0] = baud_ff;
            AST_ADDR_DATA:  nxt_prdata[7:0] = fifo_ff[rp_ff][7:0];
            default:        nxt_pslverr = 1'b1;
         endcase
      end
      if (acc && pwrite) begin
         case (paddr)
            AST_ADDR_CTRL1: nxt_ctrl1 = pwdata[7:0] & ~(8'h01 << AST_C1_RX9);
            AST_ADDR_CTRL2: nxt_ctrl2 = pwdata[7:0];
            AST_ADDR_BAUD:  nxt_baud  = pwdata[7:0];
            default: ;
         endcase
      end
      if (rd_stat) nxt_stat_rd = 1'b1;
      if ((rd_data || wr_data) && stat_rd_ff) begin
         nxt_stat_rd = 1'b0;
         nxt_pe = 1'b0;
         nxt_fe = 1'b0;
         nxt_nf = 1'b0;
         nxt_ov = 1'b0;
         nxt_adr = 1'b0;
      end
      if (rd_data && cnt_ff != 2'b00) begin
         nxt_rp  = !rp_ff;
         nxt_cnt = nxt_cnt - 2'b01;
      end
      // A completing character wins over a same-cycle flag clear.
      if (rx_done) begin
         if (cnt_ff == 2'(AST_FIFO_DEPTH)) begin
            nxt_ov = 1'b1;
         end else begin
            nxt_fifo[wp_ff] = rx_word;
            nxt_wp  = !wp_ff;
            nxt_cnt = nxt_cnt + 2'b01;
            if (rx_pe) nxt_pe = 1'b1;
            if (rx_fe) nxt_fe = 1'b1;
            if (rx_nf) nxt_nf = 1'b1;
            if (ctrl2_ff[AST_C2_ADEN] && rx_word[dbits - 4'h1])
               nxt_adr = 1'b1;
         end
      end
      if (!nxt_ctrl1[AST_C1_EN]) begin
         nxt_ctrl1[AST_C1_BRK] = 1'b0;
         nxt_ctrl2[AST_C2_TRANSMIT_ENABLE] = 1'b0;
         nxt_ctrl2[AST_C2_RECEIVE_ENABLE] = 1'b0;
         nxt_pe = 1'b0;
         nxt_fe = 1'b0;
         nxt_nf = 1'b0;
         nxt_ov = 1'b0;
         nxt_adr = 1'b0;
         nxt_cnt = 2'b00;
         nxt_wp = 1'b0;
         nxt_rp = 1'b0;
      end
      nxt_irq = |({status[AST_S_TXE], status[AST_S_TRANSMIT_IDLE_FLAG],
                   status[AST_S_RXF], ov_ff, adr_ff} &
                  {ctrl2_ff[AST_C2_TEIE], ctrl2_ff[AST_C2_TIIE],
                   ctrl2_ff[AST_C2_RIE], ctrl2_ff[AST_C2_OIE],
                   ctrl2_ff[AST_C2_ADIE]}) & en;
   end

   // ----------------------------------------------------------------
   // Transmitter
   // ----------------------------------------------------------------
   always_comb begin
      nxt_tx_st = tx_st_ff;
      nxt_hold = hold_ff;
      nxt_hold_vld = hold_vld_ff;
      nxt_frame = frame_ff;
      nxt_tx_bit = tx_bit_ff;
      nxt_tx_os = tx_os_ff;
      if (wr_data && te && !hold_vld_ff) begin
         nxt_hold = {ctrl1_ff[AST_C1_TX9], pwdata[7:0]};
         nxt_hold_vld = 1'b1;
      end
      if (os_tick) nxt_tx_os = tx_os_ff + 4'h1;
      case (tx_st_ff)
         AST_TX_IDLE: begin
            nxt_tx_os = 4'h0;
            nxt_tx_bit = 4'h0;
            if (hold_vld_ff) begin
               nxt_frame = ast_frame(hold_ff, nine, pen, parity_type_select);
               nxt_hold_vld = 1'b0;
               nxt_tx_st = AST_TX_SHIFT;
            end else if (ctrl1_ff[AST_C1_BRK] && te) begin
               nxt_tx_st = AST_TX_BREAK;
            end
         end
         AST_TX_SHIFT: if (os_tick && tx_os_ff == AST_OS_LAST) begin
            nxt_frame = {1'b1, frame_ff[11:1]};
            nxt_tx_bit = tx_bit_ff + 4'h1;
            if (tx_bit_ff >= tx_last) nxt_tx_st = AST_TX_IDLE;
         end
         AST_TX_BREAK: if (os_tick && tx_os_ff == AST_OS_LAST) begin
            if (tx_bit_ff < AST_BREAK_BITS) nxt_tx_bit = tx_bit_ff + 4'h1;
            else if (!ctrl1_ff[AST_C1_BRK]) nxt_tx_st = AST_TX_IDLE;
         end
         default: nxt_tx_st = AST_TX_IDLE;
      endcase
      if (!te) begin
         nxt_tx_st = AST_TX_IDLE;
         nxt_hold_vld = 1'b0;
      end
      nxt_line = 1'b1;
      if (nxt_tx_st == AST_TX_SHIFT) nxt_line = nxt_frame[0];
      if (nxt_tx_st == AST_TX_BREAK) nxt_line = 1'b0;
   end

   // ----------------------------------------------------------------
   // Receiver
   // ----------------------------------------------------------------
   always_comb begin
      logic        bit_v;
      logic [11:0] fb;
      bit_v = ast_maj(vote_ff);
      fb = rx_bits_ff;
      fb[rx_idx_ff] = bit_v;
      nxt_rx_st = rx_st_ff;
      nxt_rx_os = rx_os_ff;
      nxt_rx_idx = rx_idx_ff;
      nxt_rx_bits = rx_bits_ff;
      nxt_vote = vote_ff;
      nxt_noise = noise_ff;
      rx_done = 1'b0;
      rx_word = nine ? fb[9:1] : {1'b0, fb[8:1]};
      rx_pe = pen & (fb[rx_last - 4'h1] != ((^rx_word) ^ parity_type_select));
      rx_fe = !bit_v;
      rx_nf = noise_ff | (|vote_ff & ~&vote_ff);
      case (rx_st_ff)
         AST_RX_IDLE: if (re && rx_prev_ff && !rx_s2_ff) begin
            nxt_rx_st = AST_RX_RUN;
            nxt_rx_os = 4'h0;
            nxt_rx_idx = 4'h0;
            nxt_rx_bits = 12'h000;
            nxt_noise = 1'b0;
         end
         AST_RX_RUN: if (os_tick) begin
            nxt_rx_os = rx_os_ff + 4'h1;
            if (rx_os_ff >= AST_VOTE_FIRST && rx_os_ff <= AST_VOTE_LAST)
               nxt_vote[2'(rx_os_ff - AST_VOTE_FIRST)] = rx_s2_ff;
            if (rx_os_ff == AST_OS_LAST) begin
               nxt_rx_bits = fb;
               nxt_noise = rx_nf;
               nxt_rx_idx = rx_idx_ff + 4'h1;
               if (rx_idx_ff == 4'h0 && bit_v) begin
                  nxt_rx_st = AST_RX_IDLE;                // false start
               end else if (rx_idx_ff >= rx_last) begin
                  nxt_rx_st = AST_RX_IDLE;
                  rx_done = 1'b1;
               end
            end
         end
         default: nxt_rx_st = AST_RX_IDLE;
      endcase
      if (!re) nxt_rx_st = AST_RX_IDLE;
   end

   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ctrl1_ff <= AST_CTRL1_RST;
         ctrl2_ff <= AST_CTRL2_RST;
         baud_ff <= AST_BAUD_RST;
         prdata_ff <= 32'h0000_0000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         irq_ff <= 1'b0;
         stat_rd_ff <= 1'b0;
         pe_ff <= 1'b0;
         fe_ff <= 1'b0;
         nf_ff <= 1'b0;
         ov_ff <= 1'b0;
         adr_ff <= 1'b0;
         fifo_ff[0] <= 9'h000;
         fifo_ff[1] <= 9'h000;
         wp_ff <= 1'b0;
         rp_ff <= 1'b0;
         cnt_ff <= 2'b00;
         tx_st_ff <= AST_TX_IDLE;
         hold_ff <= 9'h000;
         hold_vld_ff <= 1'b0;
         frame_ff <= 12'hFFF;
         tx_bit_ff <= 4'h0;
         tx_os_ff <= 4'h0;
         line_ff <= 1'b1;
         rx_st_ff <= AST_RX_IDLE;
         rx_s1_ff <= 1'b1;
         rx_s2_ff <= 1'b1;
         rx_prev_ff <= 1'b1;
         rx_os_ff <= 4'h0;
         rx_idx_ff <= 4'h0;
         rx_bits_ff <= 12'h000;
         vote_ff <= 3'b111;
         noise_ff <= 1'b0;
      end else begin
         ctrl1_ff <= nxt_ctrl1;
         ctrl2_ff <= nxt_ctrl2;
         baud_ff <= nxt_baud;
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         irq_ff <= nxt_irq;
         stat_rd_ff <= nxt_stat_rd;
         pe_ff <= nxt_pe;
         fe_ff <= nxt_fe;
         nf_ff <= nxt_nf;
         ov_ff <= nxt_ov;
         adr_ff <= nxt_adr;
         fifo_ff <= nxt_fifo;
         wp_ff <= nxt_wp;
         rp_ff <= nxt_rp;
         cnt_ff <= nxt_cnt;
         tx_st_ff <= nxt_tx_st;
         hold_ff <= nxt_hold;
         hold_vld_ff <= nxt_hold_vld;
         frame_ff <= nxt_frame;
         tx_bit_ff <= nxt_tx_bit;
         tx_os_ff <= nxt_tx_os;
         line_ff <= nxt_line;
         rx_st_ff <= nxt_rx_st;
         rx_s1_ff <= rx_pin;
         rx_s2_ff <= rx_s1_ff;
         rx_prev_ff <= rx_s2_ff;
         rx_os_ff <= nxt_rx_os;
         rx_idx_ff <= nxt_rx_idx;
         rx_bits_ff <= nxt_rx_bits;
         vote_ff <= nxt_vote;
         noise_ff <= nxt_noise;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Pin ownership flops follow the enables one clock late.
   logic txoe_ff, rxsel_ff;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         txoe_ff <= 1'b0;
         rxsel_ff <= 1'b0;
      end else begin
         txoe_ff <= te;
         rxsel_ff <= re;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign tx_pin = line_ff;
   assign tx_pin_oe = txoe_ff;
   assign rx_serial_sel = rxsel_ff;
   assign rx_pullup_off = rxsel_ff;
   assign irq = irq_ff;

endmodule : ast_top
`default_nettype wire
